// ### lcx_pkg.sv
// Constants, types and field layout of the legacy code translator.
// Assumes one 25 MHz clock and a plain same-clock register port.
// Contract
// - Language register picks native (default), generic or three radio-format languages.
// - Legacy internal maps to path one internal one; external to path two input one.
// - Paths sharing one input are resolved by disabling the conflicting path.
// - AM code makes AM active and couples AM path depths.
// - AM plus qualifier: external sets path two AC; tones set path one.
// - AM while FM or pulse on moves those settings to AM paths.
// - FM code makes FM active and couples FM path deviations.
// - FM plus qualifier: external sets path two AC; tones set path one.
// - FM while AM or pulse on moves those settings to FM paths.
// - Digital-off code disables digital modulation, radio languages only.
// - Digital-on code clears four paths, sets radio format, then enables digital.
// - Radio format follows the selected radio language.
// - Pulse codes select DC input two and enable pulse; never internal.
// - External qualifier alone only waits for a modulation form.
// - Lone tone qualifier retunes whichever internal path is on.
// - Source-off disables pulse when pulse is the active function.
// - Source-off after a tone qualifier disables internal paths, forgets qualifier.
// - Source-off after external qualifier disables external paths, forgets qualifier.
// - Source-off with AM or FM active and no qualifier clears four paths.
// - DC FM code: FM active, pulse and AM off, FM path two DC on.
// - Codes are recognised in upper or lower case.
package lcx_pkg;
  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {LCX_LANG_NATIVE = 3'h0, LCX_LANG_GENERIC = 3'h1,
    LCX_LANG_NADC = 3'h2, LCX_LANG_PDC = 3'h3, LCX_LANG_PHS = 3'h4} lcx_lang_t;
  typedef enum logic [3:0] {LCX_CODE_NONE = 4'h0, LCX_CODE_AM = 4'h1, LCX_CODE_FM = 4'h2,
    LCX_CODE_DIG_OFF = 4'h3, LCX_CODE_DIG_ON = 4'h4, LCX_CODE_FAST_PULSE = 4'h5,
    LCX_CODE_PULSE = 4'h6, LCX_CODE_EXT_QUAL = 4'h7, LCX_CODE_LOW_TONE = 4'h8,
    LCX_CODE_HIGH_TONE = 4'h9, LCX_CODE_SRC_OFF = 4'ha, LCX_CODE_DC_FM = 4'hb} lcx_code_t;
  typedef enum logic [1:0] {LCX_SRC_NONE = 2'h0, LCX_SRC_INT1 = 2'h1, LCX_SRC_EXT1 = 2'h2,
    LCX_SRC_EXT2 = 2'h3} lcx_src_t;
  typedef enum logic [2:0] {LCX_FN_NONE = 3'h0, LCX_FN_AM = 3'h1, LCX_FN_FM = 3'h2,
    LCX_FN_PULSE = 3'h3} lcx_fn_t;
  typedef enum logic [1:0] {LCX_QUAL_NONE = 2'h0, LCX_QUAL_EXT = 2'h1, LCX_QUAL_LOW = 2'h2,
    LCX_QUAL_HIGH = 2'h3} lcx_qual_t;
  typedef enum logic [1:0] {LCX_FMT_NONE = 2'h0, LCX_FMT_NADC = 2'h1, LCX_FMT_PDC = 2'h2,
    LCX_FMT_PHS = 2'h3} lcx_fmt_t;
  // ---------------------------------------------------------------
  // Modulation state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic am1_en, am2_en, fm1_en, fm2_en, pulse_en, dm_en, radio_en;
    logic am_track, fm_track, am2_dc, fm2_dc, repeat_cont, data_ext;
    logic [10:0] am1_tone, fm1_tone;
    lcx_src_t am1_src, am2_src, fm1_src, fm2_src, pulse_src, dm_src;
    lcx_fmt_t radio_fmt;
  } lcx_mod_t;
  localparam lcx_mod_t LCX_MOD_RESET = '0;
  localparam logic [10:0] LCX_TONE_LOW_HZ = 11'h190;
  localparam logic [10:0] LCX_TONE_HIGH_HZ = 11'h3e8;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] LCX_OFS_LANG = 8'h00;
  localparam logic [7:0] LCX_OFS_CODE = 8'h04;
  localparam logic [7:0] LCX_OFS_STATUS = 8'h08;
  localparam logic [7:0] LCX_OFS_SOURCE = 8'h0c;
  localparam logic [7:0] LCX_OFS_TONE = 8'h10;
  localparam int LCX_POS_FM_TONE = 16;
  localparam int LCX_POS_FN = 12;
  localparam int LCX_POS_QUAL = 16;
  localparam int LCX_POS_FMT = 18;
  localparam int LCX_POS_LAST = 20;
  // ---------------------------------------------------------------
  // Code text, upper case
  // ---------------------------------------------------------------
  localparam logic [15:0] LCX_TXT_AM = 16'h414d;
  localparam logic [15:0] LCX_TXT_FM = 16'h464d;
  localparam logic [15:0] LCX_TXT_DIG_OFF = 16'h5030;
  localparam logic [15:0] LCX_TXT_DIG_ON = 16'h5034;
  localparam logic [15:0] LCX_TXT_FAST_PULSE = 16'h5046;
  localparam logic [15:0] LCX_TXT_PULSE = 16'h504d;
  localparam logic [15:0] LCX_TXT_EXT_QUAL = 16'h5331;
  localparam logic [15:0] LCX_TXT_LOW_TONE = 16'h5332;
  localparam logic [15:0] LCX_TXT_HIGH_TONE = 16'h5333;
  localparam logic [15:0] LCX_TXT_SRC_OFF = 16'h5334;
  localparam logic [15:0] LCX_TXT_DC_FM = 16'h5335;
endpackage

// ### lcx_code_if.sv
// Decoded code strobe between the decoder and the translator core.
// Assumes both ends on the same clock.
`timescale 1ns/1ns
interface lcx_code_if;
  import lcx_pkg::*;
  logic valid;
  lcx_code_t code;
  modport src (output valid, output code);
  modport dst (input valid, input code);
endinterface

// ### lcx_decode.sv
// Case-folding decoder from two code characters to a code strobe.
// Assumes a one-cycle strobe with the text, same clock.
`timescale 1ns/1ns
module lcx_decode import lcx_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire logic [15:0] text,
  lcx_code_if.src cif
);
  logic [15:0] folded;
  lcx_code_t code_next;
  // ---------------------------------------------------------------
  // Fold lower case letters
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_fold
    wire logic [7:0] ch = text[i*8 +: 8];
    assign folded[i*8 +: 8] = (ch >= 8'h61 && ch <= 8'h7a) ? (ch & 8'hdf) : ch;
  end
  always_comb begin
    case (folded)
      LCX_TXT_AM: code_next = LCX_CODE_AM;
      LCX_TXT_FM: code_next = LCX_CODE_FM;
      LCX_TXT_DIG_OFF: code_next = LCX_CODE_DIG_OFF;
      LCX_TXT_DIG_ON: code_next = LCX_CODE_DIG_ON;
      LCX_TXT_FAST_PULSE: code_next = LCX_CODE_FAST_PULSE;
      LCX_TXT_PULSE: code_next = LCX_CODE_PULSE;
      LCX_TXT_EXT_QUAL: code_next = LCX_CODE_EXT_QUAL;
      LCX_TXT_LOW_TONE: code_next = LCX_CODE_LOW_TONE;
      LCX_TXT_HIGH_TONE: code_next = LCX_CODE_HIGH_TONE;
      LCX_TXT_SRC_OFF: code_next = LCX_CODE_SRC_OFF;
      LCX_TXT_DC_FM: code_next = LCX_CODE_DC_FM;
      default: code_next = LCX_CODE_NONE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cif.valid <= 1'b0;
      cif.code <= LCX_CODE_NONE;
    end else begin
      cif.valid <= strobe && (code_next != LCX_CODE_NONE);
      cif.code <= code_next;
    end
  end
endmodule

// ### lcx_share_guard.sv
// Drops paths that would share one modulation input.
// Assumes the caller says which modulation type has priority.
`timescale 1ns/1ns
module lcx_share_guard import lcx_pkg::*; (
  input lcx_mod_t mod_in,
  input wire logic keep_am,
  output lcx_mod_t mod_out
);
  logic [3:0] en;
  lcx_src_t src [4];
  always_comb begin
    en = {mod_in.fm2_en, mod_in.fm1_en, mod_in.am2_en, mod_in.am1_en};
    src[0] = mod_in.am1_src;
    src[1] = mod_in.am2_src;
    src[2] = mod_in.fm1_src;
    src[3] = mod_in.fm2_src;
    // Paths 0,1 are AM, 2,3 are FM; the losing type gives way
    for (int i = 0; i < 2; i++) begin
      for (int j = 2; j < 4; j++) begin
        if (en[i] && en[j] && src[i] == src[j]) begin
          if (keep_am) en[j] = 1'b0;
          else en[i] = 1'b0;
        end
      end
    end
    mod_out = mod_in;
    {mod_out.fm2_en, mod_out.fm1_en, mod_out.am2_en, mod_out.am1_en} = en;
  end
endmodule

// ### lcx_translator.sv
// Legacy two-letter code translator: register port, language and modulation state.
// Assumes a same-clock master with one-cycle strobes and read data one cycle later.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module lcx_translator import lcx_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  output logic [6:0] path_en
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lcx_lang_t lang_reg;
  lcx_mod_t mod_reg;
  lcx_mod_t mod_next;
  lcx_mod_t mod_raw;
  lcx_fn_t fn_reg;
  lcx_fn_t fn_next;
  lcx_qual_t qual_reg;
  lcx_qual_t qual_next;
  lcx_code_t last_reg;
  lcx_code_t last_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic [6:0] path_en_reg;
  logic compat;
  logic radio_lang;
  logic none_on;
  logic am_on;
  logic fm_on;
  lcx_code_if cif ();

  // ---------------------------------------------------------------
  // Code decoding
  // ---------------------------------------------------------------
  lcx_decode u_decode (
    .clk(clk),
    .rst_n(rst_n),
    .strobe(wr_stb && addr == LCX_OFS_CODE),
    .text(wr_data[15:0]),
    .cif(cif)
  );

  // ---------------------------------------------------------------
  // Language selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lang_reg <= LCX_LANG_NATIVE;
    end else if (wr_stb && addr == LCX_OFS_LANG && wr_data[2:0] <= 3'h4) begin
      lang_reg <= lcx_lang_t'(wr_data[2:0]);
    end
  end

  assign compat = (lang_reg != LCX_LANG_NATIVE);
  assign radio_lang = (lang_reg == LCX_LANG_NADC) || (lang_reg == LCX_LANG_PDC) ||
    (lang_reg == LCX_LANG_PHS);
  assign none_on = !(mod_reg.am1_en || mod_reg.am2_en || mod_reg.fm1_en ||
    mod_reg.fm2_en || mod_reg.pulse_en || mod_reg.dm_en);
  assign am_on = mod_reg.am1_en || mod_reg.am2_en;
  assign fm_on = mod_reg.fm1_en || mod_reg.fm2_en;

  // ---------------------------------------------------------------
  // Setup helpers
  // ---------------------------------------------------------------
  function automatic logic [10:0] tone_of(input lcx_qual_t q);
    tone_of = (q == LCX_QUAL_HIGH) ? LCX_TONE_HIGH_HZ : LCX_TONE_LOW_HZ;
  endfunction

  function automatic lcx_mod_t am_setup(input lcx_mod_t m, input lcx_qual_t q,
    input logic none_st, input logic same_on);
    lcx_mod_t r;
    r = m;
    if (same_on || none_st) begin
      if (q == LCX_QUAL_EXT) begin
        r.am2_dc = 1'b0;
        r.am2_src = LCX_SRC_EXT1;
        if (none_st) r.am2_en = 1'b1;
      end else begin
        r.am1_src = LCX_SRC_INT1;
        r.am1_tone = tone_of(q);
        if (none_st) r.am1_en = 1'b1;
      end
    end else begin
      if (m.fm1_en) begin
        r.am1_src = LCX_SRC_INT1;
        r.am1_en = 1'b1;
        r.fm1_en = 1'b0;
      end
      if (m.fm2_en || m.pulse_en) begin
        r.am2_src = LCX_SRC_EXT1;
        r.am2_en = 1'b1;
        r.fm2_en = 1'b0;
        r.pulse_en = 1'b0;
      end
    end
    am_setup = r;
  endfunction

  function automatic lcx_mod_t fm_setup(input lcx_mod_t m, input lcx_qual_t q,
    input logic none_st, input logic same_on);
    lcx_mod_t r;
    r = m;
    if (same_on || none_st) begin
      if (q == LCX_QUAL_EXT) begin
        r.fm2_dc = 1'b0;
        r.fm2_src = LCX_SRC_EXT1;
        if (none_st) r.fm2_en = 1'b1;
      end else begin
        r.fm1_src = LCX_SRC_INT1;
        r.fm1_tone = tone_of(q);
        if (none_st) r.fm1_en = 1'b1;
      end
    end else begin
      if (m.am1_en) begin
        r.fm1_src = LCX_SRC_INT1;
        r.fm1_en = 1'b1;
        r.am1_en = 1'b0;
      end
      if (m.am2_en || m.pulse_en) begin
        r.fm2_src = LCX_SRC_EXT1;
        r.fm2_en = 1'b1;
        r.am2_en = 1'b0;
        r.pulse_en = 1'b0;
      end
    end
    fm_setup = r;
  endfunction

  function automatic lcx_qual_t qual_of(input lcx_code_t c);
    case (c)
      LCX_CODE_EXT_QUAL: qual_of = LCX_QUAL_EXT;
      LCX_CODE_LOW_TONE: qual_of = LCX_QUAL_LOW;
      LCX_CODE_HIGH_TONE: qual_of = LCX_QUAL_HIGH;
      default: qual_of = LCX_QUAL_NONE;
    endcase
  endfunction

  function automatic lcx_fmt_t fmt_of(input lcx_lang_t l);
    case (l)
      LCX_LANG_NADC: fmt_of = LCX_FMT_NADC;
      LCX_LANG_PDC: fmt_of = LCX_FMT_PDC;
      LCX_LANG_PHS: fmt_of = LCX_FMT_PHS;
      default: fmt_of = LCX_FMT_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Code interpretation
  // ---------------------------------------------------------------
  always_comb begin
    mod_raw = mod_reg;
    fn_next = fn_reg;
    qual_next = qual_reg;
    last_next = last_reg;
    if (cif.valid && compat) begin
      last_next = cif.code;
      qual_next = LCX_QUAL_NONE;
      case (cif.code)
        LCX_CODE_AM: begin
          fn_next = LCX_FN_AM;
          mod_raw.am_track = 1'b1;
          if (qual_reg == LCX_QUAL_EXT) begin
            mod_raw = am_setup(mod_reg, LCX_QUAL_EXT, none_on, am_on);
            mod_raw.am_track = 1'b1;
          end
        end
        LCX_CODE_FM: begin
          fn_next = LCX_FN_FM;
          mod_raw.fm_track = 1'b1;
          if (qual_reg == LCX_QUAL_EXT) begin
            mod_raw = fm_setup(mod_reg, LCX_QUAL_EXT, none_on, fm_on);
            mod_raw.fm_track = 1'b1;
          end
        end
        LCX_CODE_EXT_QUAL, LCX_CODE_LOW_TONE, LCX_CODE_HIGH_TONE: begin
          qual_next = qual_of(cif.code);
          if (last_reg == LCX_CODE_AM) begin
            mod_raw = am_setup(mod_reg, qual_of(cif.code), none_on, am_on);
          end else if (last_reg == LCX_CODE_FM) begin
            mod_raw = fm_setup(mod_reg, qual_of(cif.code), none_on, fm_on);
          end else if (cif.code != LCX_CODE_EXT_QUAL) begin
            if (mod_reg.am1_en) mod_raw.am1_tone = tone_of(qual_of(cif.code));
            if (mod_reg.fm1_en) mod_raw.fm1_tone = tone_of(qual_of(cif.code));
          end
        end
        LCX_CODE_SRC_OFF: begin
          if (fn_reg == LCX_FN_PULSE) begin
            mod_raw.pulse_en = 1'b0;
          end else if (qual_reg == LCX_QUAL_LOW || qual_reg == LCX_QUAL_HIGH) begin
            mod_raw.am1_en = 1'b0;
            mod_raw.fm1_en = 1'b0;
          end else if (qual_reg == LCX_QUAL_EXT) begin
            mod_raw.am2_en = 1'b0;
            mod_raw.fm2_en = 1'b0;
          end else if (fn_reg == LCX_FN_AM || fn_reg == LCX_FN_FM) begin
            mod_raw.am1_en = 1'b0;
            mod_raw.am2_en = 1'b0;
            mod_raw.fm1_en = 1'b0;
            mod_raw.fm2_en = 1'b0;
          end
        end
        LCX_CODE_DC_FM: begin
          fn_next = LCX_FN_FM;
          mod_raw.fm2_src = LCX_SRC_EXT1;
          mod_raw.pulse_en = 1'b0;
          mod_raw.am1_en = 1'b0;
          mod_raw.am2_en = 1'b0;
          mod_raw.fm2_dc = 1'b1;
          mod_raw.fm2_en = 1'b1;
        end
        LCX_CODE_DIG_OFF: begin
          if (radio_lang) mod_raw.dm_en = 1'b0;
        end
        LCX_CODE_DIG_ON: begin
          if (radio_lang) begin
            mod_raw.am1_en = 1'b0;
            mod_raw.am2_en = 1'b0;
            mod_raw.fm1_en = 1'b0;
            mod_raw.fm2_en = 1'b0;
            mod_raw.dm_src = LCX_SRC_INT1;
            mod_raw.radio_fmt = fmt_of(lang_reg);
            mod_raw.radio_en = 1'b1;
            mod_raw.repeat_cont = 1'b1;
            mod_raw.data_ext = 1'b1;
            mod_raw.dm_en = 1'b1;
          end
        end
        LCX_CODE_FAST_PULSE, LCX_CODE_PULSE: begin
          fn_next = LCX_FN_PULSE;
          mod_raw.pulse_src = LCX_SRC_EXT2;
          mod_raw.pulse_en = 1'b1;
        end
        default: begin
          last_next = last_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Input sharing guard
  // ---------------------------------------------------------------
  lcx_share_guard u_guard (
    .mod_in(mod_raw),
    .keep_am(fn_next == LCX_FN_AM),
    .mod_out(mod_next)
  );

  // ---------------------------------------------------------------
  // Modulation state update
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_reg <= LCX_MOD_RESET;
      path_en_reg <= 7'h00;
    end else begin
      mod_reg <= mod_next;
      path_en_reg <= {mod_next.radio_en, mod_next.dm_en, mod_next.pulse_en,
        mod_next.fm2_en, mod_next.fm1_en, mod_next.am2_en, mod_next.am1_en};
    end
  end

  // ---------------------------------------------------------------
  // Function and qualifier memory
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_reg <= LCX_FN_NONE;
      qual_reg <= LCX_QUAL_NONE;
      last_reg <= LCX_CODE_NONE;
    end else begin
      fn_reg <= fn_next;
      qual_reg <= qual_next;
      last_reg <= last_next;
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        LCX_OFS_LANG: rd_data_next[2:0] = lang_reg;
        LCX_OFS_CODE: rd_data_next[3:0] = last_reg;
        LCX_OFS_STATUS: rd_data_next[12:0] = {mod_reg.data_ext, mod_reg.repeat_cont,
          mod_reg.fm2_dc, mod_reg.am2_dc, mod_reg.fm_track, mod_reg.am_track,
          mod_reg.radio_en, mod_reg.dm_en, mod_reg.pulse_en, mod_reg.fm2_en,
          mod_reg.fm1_en, mod_reg.am2_en, mod_reg.am1_en};
        LCX_OFS_SOURCE: begin
          rd_data_next[11:0] = {mod_reg.dm_src, mod_reg.pulse_src, mod_reg.fm2_src,
            mod_reg.fm1_src, mod_reg.am2_src, mod_reg.am1_src};
          rd_data_next[LCX_POS_FN +: 3] = fn_reg;
          rd_data_next[LCX_POS_QUAL +: 2] = qual_reg;
          rd_data_next[LCX_POS_FMT +: 2] = mod_reg.radio_fmt;
        end
        LCX_OFS_TONE: begin
          rd_data_next[10:0] = mod_reg.am1_tone;
          rd_data_next[LCX_POS_FM_TONE +: 11] = mod_reg.fm1_tone;
        end
        default: rd_data_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 32'h0000_0000;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign path_en = path_en_reg;
endmodule

// ### lcx_monitor.sv
// Checker of the translator's port behaviour.
// Assumes binding to lcx_translator, one clock.
`timescale 1ns/1ns
module lcx_monitor import lcx_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rd_data,
  input wire logic [6:0] path_en
);
  logic [2:0] lang_reg;
  logic [15:0] txt;
  logic cw;
  assign txt = wr_data[15:0] | 16'h2020;
  assign cw = wr_stb && addr == LCX_OFS_CODE;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lang_reg <= 3'h0;
    end else if (wr_stb && addr == LCX_OFS_LANG && wr_data[2:0] <= 3'h4) begin
      lang_reg <= wr_data[2:0];
    end
  end
  // ----
  // Assertions
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_clear: assert property (!$past(rst_n) |-> path_en == 7'h0)
    else $error("paths not clear after reset");
  chk_native_ignore: assert property (cw && lang_reg == 3'h0 |-> ##2 $stable(path_en))
    else $error("code acted in native language");
  chk_dig_generic: assert property (cw && lang_reg == 3'h1 && txt[15:4] == 12'h703
    |-> ##2 $stable(path_en)) else $error("digital code acted in generic language");
  chk_pulse_on: assert property (cw && lang_reg != 3'h0
    && (txt == 16'h706d || txt == 16'h7066) |-> ##2 path_en[4]) else $error("pulse not on");
  chk_dig_on: assert property (cw && lang_reg >= 3'h2 && txt == 16'h7034
    |-> ##2 path_en[6:5] == 2'h3 && path_en[3:0] == 4'h0) else $error("digital on wrong");
  chk_dig_off: assert property (cw && lang_reg >= 3'h2 && txt == 16'h7030
    |-> ##2 !path_en[5]) else $error("digital off wrong");
  chk_dc_fm: assert property (cw && lang_reg != 3'h0 && txt == 16'h7335
    |-> ##2 {path_en[4:3], path_en[1:0]} == 4'h4) else $error("dc fm wrong");
  chk_no_share: assert property (!(path_en[0] && path_en[2]) && !(path_en[1] && path_en[3]))
    else $error("two paths share one input");
  cover property (cw && lang_reg >= 3'h2 && txt == 16'h7034);
  cover property (path_en[4]);
  cover property (path_en[3:2] == 2'h3);
endmodule
bind lcx_translator lcx_monitor i_lcx_monitor (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .path_en(path_en));

// ### lcx_ctrl_model.sv
// Remote controller model: register writes, reads and code text.
// Assumes the translator port on the same clock.
`timescale 1ns/1ns
module lcx_ctrl_model import lcx_pkg::*; (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [31:0] rd_data
);
  initial begin
    addr = 8'h0;
    wr_data = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
  endtask
  // Text in either case, state settled two edges on
  task automatic code(input logic [15:0] t);
    wr(LCX_OFS_CODE, {16'h0, t});
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench of the legacy code translator.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ns
module tb_top import lcx_pkg::*; ;
  logic clk, rst_n, wr_stb, rd_stb;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [6:0] path_en;
  int bad_count;
  int n_tests;
  initial clk = 1'b0;
  always #20 clk = ~clk;
  lcx_translator i_lcx_translator (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .path_en(path_en));
  lcx_ctrl_model i_lcx_ctrl_model (.clk(clk), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_lcx_ctrl_model.rd(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask
  task automatic code_path(input logic [15:0] t, input logic [6:0] exp);
    i_lcx_ctrl_model.code(t);
    check($sformatf("path_en after %s", t), {25'h0, path_en}, {25'h0, exp});
  endtask
  task automatic start(input logic [2:0] l);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    if (l != 3'h0) i_lcx_ctrl_model.wr(LCX_OFS_LANG, {29'h0, l});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    start(3'h0);
    reg_is(LCX_OFS_LANG, 32'h0);
    reg_is(LCX_OFS_STATUS, 32'h0);
    reg_is(LCX_OFS_SOURCE, 32'h0);
    reg_is(8'h14, 32'h0);
    code_path("PM", 7'h0);
    i_lcx_ctrl_model.wr(LCX_OFS_LANG, 32'h5);
    reg_is(LCX_OFS_LANG, 32'h0);
    i_lcx_ctrl_model.wr(LCX_OFS_LANG, 32'h1);
    reg_is(LCX_OFS_LANG, 32'h1);
  endtask
  task automatic t_pulse();
    start(3'h1);
    code_path("pm", 7'h10);
    reg_is(LCX_OFS_SOURCE, 32'h3300);
    code_path("S4", 7'h0);
    code_path("PF", 7'h10);
    code_path("s1", 7'h10);
    code_path("AM", 7'h02);
    code_path("S4", 7'h0);
  endtask
  task automatic t_am();
    start(3'h1);
    code_path("S1", 7'h0);
    code_path("am", 7'h02);
    reg_is(LCX_OFS_STATUS, 32'h82);
    reg_is(LCX_OFS_SOURCE, 32'h1008);
    code_path("AM", 7'h02);
    code_path("S3", 7'h02);
    reg_is(LCX_OFS_TONE, 32'h3e8);
    code_path("S4", 7'h02);
    code_path("S1", 7'h02);
    code_path("S4", 7'h0);
  endtask
  task automatic t_tone_fm();
    start(3'h1);
    code_path("AM", 7'h0);
    code_path("S2", 7'h01);
    reg_is(LCX_OFS_TONE, 32'h190);
    code_path("s3", 7'h01);
    reg_is(LCX_OFS_TONE, 32'h3e8);
    code_path("S4", 7'h0);
    code_path("AM", 7'h0);
    code_path("S2", 7'h01);
    i_lcx_ctrl_model.code("FM");
    code_path("S2", 7'h04);
    reg_is(LCX_OFS_STATUS, 32'h184);
    code_path("s5", 7'h0c);
    reg_is(LCX_OFS_STATUS, 32'h58c);
  endtask
  task automatic t_dig();
    logic [2:0] l;
    start(3'h1);
    code_path("P4", 7'h0);
    for (int i = 2; i <= 4; i++) begin
      l = 3'(i);
      start(l);
      code_path("AM", 7'h0);
      code_path("S2", 7'h01);
      code_path("p4", 7'h60);
      reg_is(LCX_OFS_STATUS, 32'h18e0);
      reg_is(LCX_OFS_SOURCE, 32'h1401 | (32'(l - 3'h1) << 18));
      code_path("P0", 7'h40);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    bad_count = 0;
    n_tests = 0;
    t_reset();
    t_pulse();
    t_am();
    t_tone_fm();
    t_dig();
    complete_run();
  end
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule
